// ==== logic/mmf_master.sv ====
// Serial master framer: builds requests, frames them, checks the reply.
// Summary of operation
// RULE_01: Only one exchange with one slave is in progress at any time.
// RULE_02: After sending, wait up to the answer delay; accept no new request meanwhile.
// RULE_03: Broadcast uses address 0; no reply is awaited or checked.
// RULE_04: Broadcast is allowed only for write codes; read broadcasts are rejected.
// RULE_05: ASCII or RTU framing is chosen per request at run time.
// RULE_06: ASCII sends each byte as two hex characters between start and end marks.
// RULE_07: RTU sends each byte as one character; silence marks telegram ends.
// RULE_08: Read codes 01h, 02h, 03h and 04h are supported.
// RULE_09: Write codes 05h, 06h, 0Fh and 10h are supported.
// RULE_10: Reply code with 80h set is an exception; unchanged code is success.
// RULE_11: Checksum appended on send and checked on receive: CRC in RTU, LRC in ASCII.
// RULE_12: Bit read sends address, code, first bit, bit count and checksum.
// RULE_13: Read reply holds address, code, byte count, up to 250 bytes, checksum.
// RULE_14: Word read sends first word and count; reply words come high byte first.
// RULE_15: Single bit write sends address and state FF00h for set, 0000h for clear.
// RULE_16: Single word write sends address and value; reply echoes both.
// RULE_17: Multi bit write sends address, bit count, byte count, up to 250 bytes.
// RULE_18: Multi word write sends address, word count, byte count, then the words.
// RULE_19: Flag missing reply after the answer delay, and a wrong checksum.
// RULE_20: Flag wrong function code and wrong slave address in the reply.
// RULE_21: CRC 16 init all ones sent low byte first; LRC is negated byte sum.
// RULE_22: In RTU, 3.5 character times of silence end a telegram.
module mmf_master #(
	parameter int unsigned T35_CYC = mmf_pkg::T35_CYC,
	parameter int unsigned ANSWER_CYC = mmf_pkg::ANSWER_CYC
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic ascii_mode,
	input wire logic req_valid,
	output logic req_ready,
	input wire logic [7:0] req_slave,
	input wire logic [7:0] req_func,
	input wire logic [15:0] req_addr,
	input wire logic [15:0] req_count,
	input wire logic req_bit,
	input wire logic [7:0] req_nbytes,
	output logic [7:0] req_data_idx,
	input wire logic [7:0] req_data,
	output logic [7:0] tx_char,
	output logic tx_valid,
	input wire logic tx_ready,
	input wire logic [7:0] rx_char,
	input wire logic rx_valid,
	output logic done,
	output mmf_pkg::mmf_status_t status,
	output logic [7:0] rsp_len,
	input wire logic [7:0] rsp_rd_idx,
	output logic [7:0] rsp_rd_data
);
	typedef enum logic [2:0] {S_IDLE, S_PRE, S_START, S_BYTE, S_CK, S_END, S_RX, S_CHECK}
		mmf_state_t;

	mmf_state_t state_reg;
	logic req_ready_reg, tx_valid_reg, done_reg, clr_reg, tx_feed_reg;
	logic [7:0] tx_char_reg, req_data_idx_reg, tx_byte_reg;
	mmf_pkg::mmf_status_t status_reg;
	logic [7:0] slave_reg, func_reg, nb_reg;
	logic [15:0] f1_reg, f2_reg, ck_word_reg;
	logic ascii_reg, multi_reg, nib_reg;
	logic [1:0] step_reg;
	logic [8:0] tx_idx_reg;
	logic [31:0] gap_reg, timer_reg;
	logic [7:0] rx_len_reg, rx_adr_reg, rx_fc_reg, rx_din_reg, rx_hi_reg;
	logic [3:0] rx_hi_nib_reg;
	logic rx_feed_reg, rx_in_frame_reg, rx_nib_reg, rx_cr_reg, rx_bad_reg, rx_ovf_reg;
	logic [7:0] rsp_rd_data_reg;
	logic [7:0] rsp_buf [0:255];
	logic [8:0] frame_len;
	logic [7:0] cur_byte;
	logic is_read, is_write, reject, rx_store, rx_done, rx_seen, ck_ok;
	logic [7:0] rx_byte;
	logic [4:0] rx_hexval;

	mmf_ck_if ck_bus ();

	mmf_cksum u_cksum (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.ck(ck_bus)
	);

	// Binary nibble to upper-case hex character
	function automatic logic [7:0] to_hex(input logic [3:0] n);
		return (n < 4'ha) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
	endfunction : to_hex

	// Hex character to nibble, top bit marks a legal digit
	function automatic logic [4:0] from_hex(input logic [7:0] c);
		if (c >= 8'h30 && c <= 8'h39) return {1'b1, 4'(c - 8'h30)};
		if (c >= 8'h41 && c <= 8'h46) return {1'b1, 4'(c - 8'h37)};
		if (c >= 8'h61 && c <= 8'h66) return {1'b1, 4'(c - 8'h57)};
		return 5'h00;
	endfunction : from_hex

	// Request classification
	assign is_read = (req_func >= mmf_pkg::FC_RD_OBITS) && (req_func <= mmf_pkg::FC_RD_IWORDS);
	assign is_write = (req_func == mmf_pkg::FC_WR_BIT) || (req_func == mmf_pkg::FC_WR_WORD)
		|| (req_func == mmf_pkg::FC_WR_BITS) || (req_func == mmf_pkg::FC_WR_WORDS);
	assign reject = !(is_read || is_write) // [RULE_08] [RULE_09]
		|| (is_read && req_slave == mmf_pkg::BCAST_ADR) // [RULE_04]
		|| (req_nbytes > mmf_pkg::MAX_DATA_BYTES); // [RULE_17]
	assign frame_len = multi_reg ? (mmf_pkg::DATA_BASE + {1'b0, nb_reg}) : mmf_pkg::HDR_LEN;

	// Telegram byte at the current index, words high byte first
	always_comb begin
		unique case (tx_idx_reg)
			9'h000: cur_byte = slave_reg;
			9'h001: cur_byte = func_reg;
			9'h002: cur_byte = f1_reg[15:8]; // [RULE_12] [RULE_14]
			9'h003: cur_byte = f1_reg[7:0];
			9'h004: cur_byte = f2_reg[15:8]; // [RULE_16]
			9'h005: cur_byte = f2_reg[7:0];
			9'h006: cur_byte = nb_reg; // [RULE_17] [RULE_18]
			default: cur_byte = req_data;
		endcase
	end

	// Checksum feed from whichever side is active
	assign ck_bus.clear = clr_reg;
	assign ck_bus.feed = tx_feed_reg | rx_feed_reg;
	assign ck_bus.din = tx_feed_reg ? tx_byte_reg : rx_din_reg;
	assign ck_ok = ascii_reg ? (ck_bus.sum == mmf_pkg::SUM_INIT) : (ck_bus.crc == 16'h0000);

	// Main sequence: accept, send, await, evaluate
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= S_IDLE;
			req_ready_reg <= 1'b0;
			tx_valid_reg <= 1'b0;
			tx_char_reg <= 8'h00;
			tx_feed_reg <= 1'b0;
			tx_byte_reg <= 8'h00;
			done_reg <= 1'b0;
			clr_reg <= 1'b0;
			status_reg <= mmf_pkg::ST_OK;
			slave_reg <= 8'h00;
			func_reg <= 8'h00;
			nb_reg <= 8'h00;
			f1_reg <= 16'h0000;
			f2_reg <= 16'h0000;
			ck_word_reg <= 16'h0000;
			ascii_reg <= 1'b0;
			multi_reg <= 1'b0;
			nib_reg <= 1'b0;
			step_reg <= 2'h0;
			tx_idx_reg <= 9'h000;
		end else begin
			done_reg <= 1'b0;
			clr_reg <= 1'b0;
			tx_feed_reg <= 1'b0;
			if (tx_valid_reg && tx_ready)
				tx_valid_reg <= 1'b0;
			unique case (state_reg)
				S_IDLE: begin
					req_ready_reg <= 1'b1;
					if (req_valid && req_ready_reg) begin
						req_ready_reg <= 1'b0; // [RULE_01] [RULE_02]
						slave_reg <= req_slave;
						func_reg <= req_func;
						f1_reg <= req_addr;
						f2_reg <= (req_func == mmf_pkg::FC_WR_BIT) ? // [RULE_15]
							(req_bit ? mmf_pkg::COIL_ON : mmf_pkg::COIL_OFF) : req_count;
						nb_reg <= req_nbytes;
						multi_reg <= (req_func == mmf_pkg::FC_WR_BITS)
							|| (req_func == mmf_pkg::FC_WR_WORDS);
						ascii_reg <= ascii_mode; // [RULE_05]
						tx_idx_reg <= 9'h000;
						nib_reg <= 1'b0;
						step_reg <= 2'h0;
						clr_reg <= 1'b1;
						if (reject) begin
							status_reg <= mmf_pkg::ST_REJECT; // [RULE_04]
							done_reg <= 1'b1;
						end else begin
							state_reg <= ascii_mode ? S_START : S_PRE;
						end
					end
				end
				S_PRE: begin
					if (gap_reg >= T35_CYC)
						state_reg <= S_BYTE; // [RULE_07]
				end
				S_START: begin
					if (!tx_valid_reg) begin
						tx_char_reg <= mmf_pkg::CH_START; // [RULE_06]
						tx_valid_reg <= 1'b1;
						state_reg <= S_BYTE;
					end
				end
				S_BYTE: begin
					if (!tx_valid_reg) begin
						if (tx_idx_reg == frame_len) begin
							ck_word_reg <= ascii_reg ? {8'h00, 8'(8'h00 - ck_bus.sum)} : ck_bus.crc;
							state_reg <= S_CK; // [RULE_11]
						end else begin
							tx_valid_reg <= 1'b1;
							if (!ascii_reg || !nib_reg) begin
								tx_byte_reg <= cur_byte;
								tx_feed_reg <= 1'b1;
							end
							if (!ascii_reg) begin
								tx_char_reg <= cur_byte; // [RULE_07]
								tx_idx_reg <= tx_idx_reg + 9'h001;
							end else if (!nib_reg) begin
								tx_char_reg <= to_hex(cur_byte[7:4]); // [RULE_06]
								nib_reg <= 1'b1;
							end else begin
								tx_char_reg <= to_hex(cur_byte[3:0]);
								nib_reg <= 1'b0;
								tx_idx_reg <= tx_idx_reg + 9'h001;
							end
						end
					end
				end
				S_CK: begin
					if (!tx_valid_reg) begin
						tx_valid_reg <= 1'b1;
						if (ascii_reg)
							tx_char_reg <= to_hex(step_reg[0] ? ck_word_reg[3:0] : ck_word_reg[7:4]);
						else
							tx_char_reg <= step_reg[0] ? ck_word_reg[15:8] : ck_word_reg[7:0]; // [RULE_21]
						step_reg <= step_reg[0] ? 2'h0 : 2'h1;
						if (step_reg[0])
							state_reg <= S_END;
					end
				end
				S_END: begin
					if (!tx_valid_reg) begin
						if (ascii_reg && step_reg != 2'h2) begin
							tx_char_reg <= (step_reg == 2'h0) ? mmf_pkg::CH_CR : mmf_pkg::CH_LF;
							tx_valid_reg <= 1'b1; // [RULE_06]
							step_reg <= step_reg + 2'h1;
						end else if (slave_reg == mmf_pkg::BCAST_ADR) begin
							status_reg <= mmf_pkg::ST_OK; // [RULE_03]
							done_reg <= 1'b1;
							state_reg <= S_IDLE;
						end else begin
							clr_reg <= 1'b1;
							state_reg <= S_RX;
						end
					end
				end
				S_RX: begin
					if (rx_done) begin
						state_reg <= S_CHECK;
					end else if (!rx_seen && timer_reg >= ANSWER_CYC) begin
						status_reg <= mmf_pkg::ST_TIMEOUT; // [RULE_19] [RULE_02]
						done_reg <= 1'b1;
						state_reg <= S_IDLE;
					end
				end
				S_CHECK: begin
					done_reg <= 1'b1;
					state_reg <= S_IDLE;
					if (rx_ovf_reg)
						status_reg <= mmf_pkg::ST_LONG; // [RULE_13]
					else if (rx_bad_reg || rx_len_reg < mmf_pkg::RX_MIN_LEN || !ck_ok)
						status_reg <= mmf_pkg::ST_CKSUM; // [RULE_19] [RULE_11]
					else if (rx_adr_reg != slave_reg)
						status_reg <= mmf_pkg::ST_ADDR; // [RULE_20]
					else if ((rx_fc_reg & ~mmf_pkg::EXC_FLAG) != func_reg)
						status_reg <= mmf_pkg::ST_FUNC; // [RULE_20]
					else if ((rx_fc_reg & mmf_pkg::EXC_FLAG) != 8'h00)
						status_reg <= mmf_pkg::ST_EXCEPT; // [RULE_10]
					else
						status_reg <= mmf_pkg::ST_OK; // [RULE_10]
				end
			endcase
		end
	end

	// Data byte index presented ahead of use
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			req_data_idx_reg <= 8'h00;
		else
			req_data_idx_reg <= 8'(tx_idx_reg - mmf_pkg::DATA_BASE);
	end

	// Line silence since last character either way
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			gap_reg <= 32'h00000000;
		else if ((tx_valid_reg && tx_ready) || rx_valid)
			gap_reg <= 32'h00000000;
		else if (gap_reg < T35_CYC)
			gap_reg <= gap_reg + 32'h00000001; // [RULE_22]
	end

	// Answer delay, runs only while awaiting the first reply character
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			timer_reg <= 32'h00000000;
		else if (state_reg != S_RX || rx_seen)
			timer_reg <= 32'h00000000;
		else
			timer_reg <= timer_reg + 32'h00000001; // [RULE_02]
	end

	// Decode of an incoming character
	assign rx_hexval = from_hex(rx_char);
	assign rx_seen = (rx_len_reg != 8'h00) || rx_in_frame_reg;
	assign rx_done = ascii_reg ? rx_cr_reg : ((rx_len_reg != 8'h00) && gap_reg >= T35_CYC); // [RULE_22]
	always_comb begin
		rx_store = 1'b0;
		rx_byte = rx_char;
		if (state_reg == S_RX && rx_valid) begin
			if (!ascii_reg) begin
				rx_store = 1'b1; // [RULE_07]
			end else if (rx_in_frame_reg && rx_nib_reg && rx_char != mmf_pkg::CH_CR
				&& rx_char != mmf_pkg::CH_LF && rx_char != mmf_pkg::CH_START) begin
				rx_store = 1'b1; // [RULE_06]
				rx_byte = {rx_hi_nib_reg, rx_hexval[3:0]};
			end
		end
	end

	// Reply capture and framing
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_len_reg <= 8'h00;
			rx_adr_reg <= 8'h00;
			rx_fc_reg <= 8'h00;
			rx_din_reg <= 8'h00;
			rx_hi_nib_reg <= 4'h0;
			rx_feed_reg <= 1'b0;
			rx_in_frame_reg <= 1'b0;
			rx_nib_reg <= 1'b0;
			rx_cr_reg <= 1'b0;
			rx_bad_reg <= 1'b0;
			rx_ovf_reg <= 1'b0;
		end else if (clr_reg) begin
			rx_len_reg <= 8'h00;
			rx_feed_reg <= 1'b0;
			rx_in_frame_reg <= 1'b0;
			rx_nib_reg <= 1'b0;
			rx_cr_reg <= 1'b0;
			rx_bad_reg <= 1'b0;
			rx_ovf_reg <= 1'b0;
		end else begin
			rx_feed_reg <= 1'b0;
			if (state_reg == S_RX && rx_valid && ascii_reg) begin
				if (rx_char == mmf_pkg::CH_START) begin
					rx_in_frame_reg <= 1'b1;
					rx_len_reg <= 8'h00;
					rx_nib_reg <= 1'b0;
				end else if (rx_in_frame_reg && rx_char == mmf_pkg::CH_CR) begin
					rx_cr_reg <= 1'b1;
				end else if (rx_in_frame_reg && rx_char != mmf_pkg::CH_LF) begin
					if (!rx_hexval[4])
						rx_bad_reg <= 1'b1;
					rx_hi_nib_reg <= rx_hexval[3:0];
					rx_nib_reg <= !rx_nib_reg;
				end
			end
			if (rx_store) begin
				if (rx_len_reg == mmf_pkg::RX_FULL) begin
					rx_ovf_reg <= 1'b1;
				end else begin
					rx_len_reg <= rx_len_reg + 8'h01;
					rx_din_reg <= rx_byte;
					rx_feed_reg <= 1'b1; // [RULE_11]
					if (rx_len_reg == 8'h00)
						rx_adr_reg <= rx_byte;
					if (rx_len_reg == 8'h01)
						rx_fc_reg <= rx_byte;
				end
			end
		end
	end

	// Reply buffer and its read port
	always_ff @(posedge core_clk) begin
		if (rx_store && rx_len_reg != mmf_pkg::RX_FULL)
			rsp_buf[rx_len_reg] <= rx_byte; // [RULE_13] [RULE_14]
	end
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			rsp_rd_data_reg <= 8'h00;
		else
			rsp_rd_data_reg <= rsp_buf[rsp_rd_idx];
	end

	assign req_ready = req_ready_reg;
	assign req_data_idx = req_data_idx_reg;
	assign tx_char = tx_char_reg;
	assign tx_valid = tx_valid_reg;
	assign done = done_reg;
	assign status = status_reg;
	assign rsp_len = rx_len_reg;
	assign rsp_rd_data = rsp_rd_data_reg;
endmodule : mmf_master

// ==== logic/mmf_pkg.sv ====
// Constants and types shared by the serial master framer.
package mmf_pkg;
	// Timing, all in the units stated by the name
	localparam int unsigned CLK_PERIOD_NS = 10;
	localparam int unsigned CHAR_TIME_NS = 1145834; // One 11-bit character at 9600 baud
	localparam int unsigned T35_CYC = (7 * CHAR_TIME_NS + 2 * CLK_PERIOD_NS - 1)
		/ (2 * CLK_PERIOD_NS);
	localparam int unsigned ANSWER_DELAY_NS = 100000000;
	localparam int unsigned ANSWER_CYC = ANSWER_DELAY_NS / CLK_PERIOD_NS;
	// Function codes
	localparam logic [7:0] FC_RD_OBITS = 8'h01;
	localparam logic [7:0] FC_RD_IBITS = 8'h02;
	localparam logic [7:0] FC_RD_OWORDS = 8'h03;
	localparam logic [7:0] FC_RD_IWORDS = 8'h04;
	localparam logic [7:0] FC_WR_BIT = 8'h05;
	localparam logic [7:0] FC_WR_WORD = 8'h06;
	localparam logic [7:0] FC_WR_BITS = 8'h0f;
	localparam logic [7:0] FC_WR_WORDS = 8'h10;
	localparam logic [7:0] EXC_FLAG = 8'h80;
	localparam logic [7:0] BCAST_ADR = 8'h00;
	localparam logic [15:0] COIL_ON = 16'hff00;
	localparam logic [15:0] COIL_OFF = 16'h0000;
	localparam logic [7:0] MAX_DATA_BYTES = 8'hfa; // 250
	// Framing characters and layout
	localparam logic [7:0] CH_START = 8'h3a;
	localparam logic [7:0] CH_CR = 8'h0d;
	localparam logic [7:0] CH_LF = 8'h0a;
	localparam logic [8:0] HDR_LEN = 9'h006;
	localparam logic [8:0] DATA_BASE = 9'h007;
	localparam logic [7:0] RX_MIN_LEN = 8'h03;
	localparam logic [7:0] RX_FULL = 8'hff;
	// Checksum
	localparam logic [15:0] CRC_INIT = 16'hffff;
	localparam logic [15:0] CRC_POLY = 16'ha001;
	localparam logic [7:0] SUM_INIT = 8'h00;
	// Outcome of one exchange
	typedef enum logic [2:0] {
		ST_OK, ST_EXCEPT, ST_TIMEOUT, ST_CKSUM, ST_FUNC, ST_ADDR, ST_REJECT, ST_LONG
	} mmf_status_t;
endpackage : mmf_pkg

// ==== logic/mmf_ck_if.sv ====
// Checksum request and result bundle between framer and checksum unit.
interface mmf_ck_if;
	logic clear;
	logic feed;
	logic [7:0] din;
	logic [15:0] crc;
	logic [7:0] sum;
	modport engine (input clear, input feed, input din, output crc, output sum);
	modport user (output clear, output feed, output din, input crc, input sum);
endinterface : mmf_ck_if

// ==== logic/mmf_cksum.sv ====
// Running CRC and byte sum over the bytes of one telegram.
module mmf_cksum (
	input wire logic core_clk,
	input wire logic rst_n,
	mmf_ck_if.engine ck
);
	// One byte through the reflected CRC
	function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
		logic [15:0] r;
		r = c ^ {8'h00, b};
		for (int i = 0; i < 8; i++) begin
			r = r[0] ? ((r >> 1) ^ mmf_pkg::CRC_POLY) : (r >> 1);
		end
		return r;
	endfunction : crc_step

	// Both sums run in parallel; mode picks which one is used
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ck.crc <= mmf_pkg::CRC_INIT;
			ck.sum <= mmf_pkg::SUM_INIT;
		end else if (ck.clear) begin
			ck.crc <= mmf_pkg::CRC_INIT;
			ck.sum <= mmf_pkg::SUM_INIT;
		end else if (ck.feed) begin
			ck.crc <= crc_step(ck.crc, ck.din); // [RULE_21]
			ck.sum <= 8'(ck.sum + ck.din); // [RULE_21]
		end
	end
endmodule : mmf_cksum

// ==== sim/mmf_master_chk.sv ====
// Port-level assertions for the serial master framer.
module mmf_master_chk #(
	parameter int unsigned T35_CYC = mmf_pkg::T35_CYC,
	parameter int unsigned ANSWER_CYC = mmf_pkg::ANSWER_CYC
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic ascii_mode,
	input wire logic req_valid,
	input wire logic req_ready,
	input wire logic [7:0] req_slave,
	input wire logic [7:0] req_func,
	input wire logic [7:0] req_nbytes,
	input wire logic [7:0] tx_char,
	input wire logic tx_valid,
	input wire logic tx_ready,
	input wire logic rx_valid,
	input wire logic done,
	input wire mmf_pkg::mmf_status_t status
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	logic take, rd, wr;
	int unsigned q_tx, q_rx;
	// Request decode
	assign take = req_valid && req_ready;
	assign rd = req_func inside {[mmf_pkg::FC_RD_OBITS:mmf_pkg::FC_RD_IWORDS]};
	assign wr = req_func inside {[mmf_pkg::FC_WR_BIT:mmf_pkg::FC_WR_WORD], 8'h0f, 8'h10};
	// Quiet cycles of the exchange since the last character
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) q_tx <= 32'h0;
		else if (req_ready || (tx_valid && tx_ready) || rx_valid) q_tx <= 32'h0;
		else q_tx <= q_tx + 32'h1;
	end
	// Quiet cycles since the last received character, saturating
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) q_rx <= 32'h0;
		else if (rx_valid) q_rx <= 32'h0;
		else if (q_rx < 32'hfffff) q_rx <= q_rx + 32'h1;
	end
	property p_rej_read;
		take && rd && req_slave == mmf_pkg::BCAST_ADR |=> done && status == mmf_pkg::ST_REJECT;
	endproperty
	a_rej_read: assert property (p_rej_read) else $error("read broadcast taken");
	property p_rej_code;
		take && !rd && !wr |=> done && status == mmf_pkg::ST_REJECT;
	endproperty
	a_rej_code: assert property (p_rej_code) else $error("unknown code taken");
	property p_rej_len;
		take && req_func > 8'h0e && req_nbytes > 8'hfa |=> done && status == mmf_pkg::ST_REJECT;
	endproperty
	a_rej_len: assert property (p_rej_len) else $error("long write taken");
	property p_busy;
		take |=> !req_ready;
	endproperty
	a_busy: assert property (p_busy) else $error("ready during exchange");
	property p_done;
		done |-> !req_ready ##1 !done;
	endproperty
	a_done: assert property (p_done) else $error("done shape wrong");
	property p_tx_hold;
		tx_valid && !tx_ready |=> tx_valid && $stable(tx_char);
	endproperty
	a_tx_hold: assert property (p_tx_hold) else $error("tx char not held");
	property p_ascii_chr;
		tx_valid && ascii_mode |-> tx_char inside {8'h3a, 8'h0d, 8'h0a, [8'h30:8'h39], [8'h41:8'h46]};
	endproperty
	a_ascii_chr: assert property (p_ascii_chr) else $error("bad ascii char");
	property p_tmo;
		done && status == mmf_pkg::ST_TIMEOUT |-> q_tx >= ANSWER_CYC;
	endproperty
	a_tmo: assert property (p_tmo) else $error("early timeout");
	property p_wait;
		!req_ready |-> q_tx <= ANSWER_CYC + 8;
	endproperty
	a_wait: assert property (p_wait) else $error("answer wait too long");
	property p_rtu_end;
		done && !ascii_mode |-> q_rx >= T35_CYC;
	endproperty
	a_rtu_end: assert property (p_rtu_end) else $error("rtu end too early");
endmodule : mmf_master_chk

bind mmf_master mmf_master_chk #(.T35_CYC(T35_CYC), .ANSWER_CYC(ANSWER_CYC)) u_chk (
	.core_clk(core_clk), .rst_n(rst_n), .ascii_mode(ascii_mode), .req_valid(req_valid),
	.req_ready(req_ready), .req_slave(req_slave), .req_func(req_func),
	.req_nbytes(req_nbytes), .tx_char(tx_char), .tx_valid(tx_valid), .tx_ready(tx_ready),
	.rx_valid(rx_valid), .done(done), .status(status));

// ==== sim/mmf_slave_model.sv ====
// Behavioural slave station answering the master framer.
module mmf_slave_model #(
	parameter int T35_CYC = 20
) (
	input wire logic core_clk,
	input wire logic ascii,
	input wire logic [2:0] fault,
	input wire logic [7:0] tx_char,
	input wire logic tx_valid,
	output logic tx_ready,
	output logic [7:0] rx_char,
	output logic rx_valid
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] rq[$];
	logic [7:0] rs[$];
	logic [15:0] lf = 16'hace1;
	logic [7:0] acc, lc;
	logic hi, st, fin;
	int q, sp, bad;
	// Checksum helpers
	function automatic logic [15:0] crc16(logic [7:0] b[$]);
		logic [15:0] c = 16'hffff;
		foreach (b[i]) begin
			c ^= {8'h00, b[i]};
			repeat (8) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
		end
		return c;
	endfunction : crc16
	function automatic logic [7:0] lrc(logic [7:0] b[$]);
		logic [7:0] s = 8'h00;
		foreach (b[i]) s += b[i];
		return -s;
	endfunction : lrc
	function automatic logic [7:0] hc(logic [3:0] v);
		return v < 4'ha ? 8'h30 + 8'(v) : 8'h37 + 8'(v);
	endfunction : hc
	// Reply: echo for writes, pattern for reads; fault picks one defect
	task automatic answer();
		logic [7:0] b[$];
		logic [15:0] c;
		int n;
		b = {rq[0], rq[1]};
		if (fault == 3'h5) b[0] += 8'h01;
		if (fault == 3'h4) b[1] ^= 8'h40;
		n = rq[1] < 8'h03 ? ({rq[4], rq[5]} + 7) / 8 : 2 * {rq[4], rq[5]};
		if (fault == 3'h1) begin
			b[1] |= 8'h80;
			b.push_back(8'h02);
		end else if (rq[1] < 8'h05) begin
			b.push_back(8'(n));
			for (int i = 0; i < n; i++) b.push_back(8'(i) ^ 8'h5a);
		end else for (int i = 2; i < 6; i++) b.push_back(rq[i]);
		if (fault == 3'h7) repeat (256) b.push_back(8'h00); // Overlong reply
		c = crc16(b);
		if (ascii) b.push_back(lrc(b));
		else b = {b, c[7:0], c[15:8]};
		if (fault == 3'h3) b[b.size() - 1] ^= 8'h01;
		if (!ascii) rs = b;
		else begin
			rs = {8'h3a};
			foreach (b[i]) rs = {rs, hc(b[i][7:4]), hc(b[i][3:0])};
			rs = {rs, 8'h0d, 8'h0a};
		end
		sp = 0; // Line turnaround before the first reply char
	endtask : answer
	// Accept characters with stalls, detect telegram end, send reply
	initial begin
		{tx_ready, rx_valid, rx_char, hi, st, q, sp, bad} = '0;
		forever begin
			@(posedge core_clk);
			fin = 1'b0;
			q++;
			lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
			rx_valid <= 1'b0;
			if (tx_valid && tx_ready) begin
				q = 0;
				if (!ascii) rq.push_back(tx_char);
				else if (tx_char == 8'h3a) begin
					st = 1'b1;
					hi = 1'b0;
				end else if (tx_char == 8'h0a) begin
					bad += int'(lc != 8'h0d || !st);
					fin = 1'b1;
					st = 1'b0;
				end else if (tx_char != 8'h0d) begin
					acc = {acc[3:0], 4'(tx_char - (tx_char > 8'h39 ? 8'h37 : 8'h30))};
					hi = !hi;
					if (!hi) rq.push_back(acc);
				end
				lc = tx_char;
			end
			if (!ascii && q == T35_CYC && rq.size() > 0) fin = 1'b1;
			if (fin && rq[0] != 8'h00 && fault != 3'h2) answer();
			if (rs.size() > 0 && ++sp % 3 == 0) begin
				rx_char <= rs.pop_front();
				rx_valid <= 1'b1;
			end
			tx_ready <= lf[0] | lf[3];
		end
	end
endmodule : mmf_slave_model

// ==== sim/modbus_serial_master_framer_test.sv ====
// Self-checking bench for the serial master framer against a slave model.
module modbus_serial_master_framer_test;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int unsigned T35 = 20;
	localparam int unsigned ANS = 500;
	logic core_clk = 1'b0, rst_n = 1'b0, ascii_mode = 1'b0, req_valid = 1'b0, req_bit = 1'b0;
	logic req_ready, tx_valid, tx_ready, rx_valid, done;
	logic [7:0] req_slave = 8'h00, req_func = 8'h00, req_nbytes = 8'h00, rsp_rd_idx = 8'h00;
	logic [7:0] req_data_idx, req_data, tx_char, rx_char, rsp_len, rsp_rd_data, ds = 8'h00;
	logic [15:0] req_addr = 16'h0000, req_count = 16'h0000;
	logic [2:0] fault = 3'h0;
	logic [31:0] seed = 32'h4d;
	mmf_pkg::mmf_status_t status;
	int n_errors = 0, n_checks = 0;
	// Data bytes follow their index
	assign req_data = req_data_idx ^ ds;
	mmf_master #(.T35_CYC(T35), .ANSWER_CYC(ANS)) dut (.core_clk(core_clk), .rst_n(rst_n),
		.ascii_mode(ascii_mode), .req_valid(req_valid), .req_ready(req_ready),
		.req_slave(req_slave), .req_func(req_func), .req_addr(req_addr), .req_count(req_count),
		.req_bit(req_bit), .req_nbytes(req_nbytes), .req_data_idx(req_data_idx),
		.req_data(req_data), .tx_char(tx_char), .tx_valid(tx_valid), .tx_ready(tx_ready),
		.rx_char(rx_char), .rx_valid(rx_valid), .done(done), .status(status),
		.rsp_len(rsp_len), .rsp_rd_idx(rsp_rd_idx), .rsp_rd_data(rsp_rd_data));
	mmf_slave_model #(.T35_CYC(T35)) slv (.core_clk(core_clk), .ascii(ascii_mode), .fault(fault),
		.tx_char(tx_char), .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_char(rx_char),
		.rx_valid(rx_valid));
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	task automatic final_report();
		$display("checks %0d mismatches %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : final_report
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// Bounded wait for done (sel 1) or ready (sel 0)
	task automatic wait_hi(input logic sel);
		int i;
		for (i = 0; i < 4000; i++) begin
			#1;
			if (sel ? done === 1'b1 : req_ready === 1'b1) break;
			@(posedge core_clk);
		end
		if (i == 4000) begin
			n_errors++;
			final_report();
		end
	endtask : wait_hi
	// One exchange: request, outcome, sent frame and stored reply
	task automatic run(input logic am, input logic [7:0] sa, input logic [7:0] fc,
		input logic [2:0] fl, input logic [7:0] nb);
		logic [7:0] e[$];
		logic [15:0] f2, c;
		logic rej;
		int n;
		wait_hi(1'b0);
		slv.rq.delete();
		rej = !(fc inside {[8'h01:8'h06], 8'h0f, 8'h10}) || (sa == 8'h00 && fc < 8'h05) || nb > 8'hfa;
		@(posedge core_clk);
		ascii_mode <= am;
		fault <= fl;
		req_slave <= sa;
		req_func <= fc;
		req_addr <= 16'(rnd());
		req_count <= 16'(rnd() % 8 + 1);
		req_bit <= 1'(rnd());
		req_nbytes <= nb;
		ds <= 8'(rnd());
		rsp_rd_idx <= 8'(n_checks % 2);
		req_valid <= 1'b1;
		@(posedge core_clk);
		req_valid <= 1'b0;
		wait_hi(1'b1);
		chk(16'(status), rej ? 16'h6 : sa == 8'h00 ? 16'h0 : 16'(fl));
		f2 = fc == 8'h05 ? (req_bit ? 16'hff00 : 16'h0000) : req_count;
		e = {sa, fc, req_addr[15:8], req_addr[7:0], f2[15:8], f2[7:0]};
		if (fc > 8'h0e) begin
			e.push_back(nb);
			for (int i = 0; i < nb; i++) e.push_back(8'(i) ^ ds);
		end
		c = slv.crc16(e);
		if (am) e.push_back(slv.lrc(e));
		else e = {e, c[7:0], c[15:8]};
		if (rej) e.delete();
		chk(16'(slv.rq.size()), 16'(e.size()));
		foreach (e[i]) chk({8'h00, slv.rq[i]}, {8'h00, e[i]});
		if (!rej && sa != 8'h00 && fl != 3'h2) begin
			n = fl == 3'h1 ? 3 : fc > 8'h04 ? 6 : 3 + (fc < 8'h03 ? (req_count + 7) / 8 : 2 * req_count);
			chk(16'(rsp_len), fl == 3'h7 ? 16'h00ff : 16'(n + (am ? 1 : 2)));
			e = {sa + 8'(fl == 3'h5), fl == 3'h1 ? fc | 8'h80 : fl == 3'h4 ? fc ^ 8'h40 : fc};
			chk({8'h00, rsp_rd_data}, {8'h00, e[rsp_rd_idx]});
		end
		$display("exchange fc %h slave %h ascii %0d done", fc, sa, am);
	endtask : run
	// Clock
	initial begin
		forever #5 core_clk = !core_clk;
	end
	// Main sequence: every code in both modes, faults, broadcast, refusals, random
	initial begin
		logic [7:0] codes[8] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h0f, 8'h10};
		logic [31:0] r;
		repeat (5) @(posedge core_clk);
		rst_n <= 1'b1;
		for (int m = 0; m < 2; m++) foreach (codes[i]) run(1'(m), 8'(rnd() % 247 + 1), codes[i], 3'h0, 8'(rnd() % 8 + 1));
		for (int f = 1; f < 6; f++) run(1'(f % 2), 8'h11, 8'h03, 3'(f), 8'h02);
		run(1'b0, 8'h11, 8'h03, 3'h7, 8'h02);
		run(1'b0, 8'h00, 8'h06, 3'h0, 8'h01);
		run(1'b1, 8'h00, 8'h0f, 3'h0, 8'h03);
		run(1'b0, 8'h00, 8'h01, 3'h0, 8'h01);
		run(1'b0, 8'h07, 8'h07, 3'h0, 8'h01);
		run(1'b1, 8'h07, 8'h10, 3'h0, 8'hfb);
		run(1'b0, 8'h07, 8'h10, 3'h0, 8'hfa);
		repeat (12) begin
			r = rnd();
			run(r[0], 8'(r[15:8] % 247 + 1), codes[r[3:1]], 3'h0, 8'(r[7:4]) + 8'h01);
		end
		chk(16'(slv.bad), 16'h0000);
		final_report();
	end
endmodule : modbus_serial_master_framer_test
